// File: src/hostport_consts.svh
// constants of the host parallel port: selects, internal addresses, field positions
`ifndef HOSTPORT_CONSTS_SVH
`define HOSTPORT_CONSTS_SVH

// command select codes
`define SEL_PACKET      3'h0
`define SEL_REGISTER    3'h1
`define SEL_PTR_LOW     3'h2
`define SEL_PTR_HIGH    3'h3
`define SEL_IDLE        3'h7

// internal register addresses
`define ADDR_PHY_MGMT_IRQ_CLEAR  16'h1806
`define ADDR_EEPROM_IRQ_CLEAR    16'h1c04
`define ADDR_IRQ_CAUSE_STATUS    16'h2000
`define ADDR_RX_PACKET_IRQ_CLEAR 16'h6403
`define ADDR_TX_DONE_IRQ_CLEAR   16'h6411

// cause bit positions
`define CAUSE_PHY_MGMT  0
`define CAUSE_EEPROM    1
`define CAUSE_RX_PACKET 2
`define CAUSE_TX_DONE   3
`define CAUSE_COUNT     4

// controller apb map
`define APB_CTRL        12'h000
`define APB_ADDR        12'h004
`define APB_WDATA       12'h008
`define APB_RDATA       12'h00c
`define APB_STATUS      12'h010
`define APB_IRQ_MASK    12'h014
`define APB_IRQ_STATUS  12'h018

// controller field positions
`define CTRL_GO         0
`define CTRL_WRITE      1
`define CTRL_SEL_LSB    4
`define STATUS_BUSY     0
`define STATUS_IRQ_PIN  1
`define EV_DONE         0
`define EV_DEVICE_IRQ   1

// strobe timing in pclk cycles
`define STROBE_CYCLES   8'h04
`define SETUP_CYCLES    8'h02

`endif

// File: src/hostport_pkg.sv
// types used by the host end of the host parallel port
package hostport_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD   = 4'b1000
    } host_state_t;

    typedef logic [15:0] host_word_t;
endpackage

// File: src/host_port_if.sv
// link between host controller and switch host port
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
    logic [2:0] cmd_select;
    logic [15:0] host_data_out;
    logic host_data_oe;
    logic [15:0] dev_data_out;
    logic dev_data_oe;
    logic port_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic irq_out;
    logic [15:0] host_data_bus;

    // resolved level of the shared data bus
    assign host_data_bus = host_data_oe ? host_data_out :
                           (dev_data_oe ? dev_data_out : 16'h0000);

    modport device (
        input cmd_select,
        input host_data_bus,
        input port_select_n,
        input read_strobe_n,
        input write_strobe_n,
        output dev_data_out,
        output dev_data_oe,
        output irq_out
    );

    modport host (
        output cmd_select,
        output host_data_out,
        output host_data_oe,
        output port_select_n,
        output read_strobe_n,
        output write_strobe_n,
        input host_data_bus,
        input irq_out
    );
endinterface
`default_nettype wire

// File: src/switch_host_port.sv
// device end of the host parallel port: pointer, packet data, interrupt causes
`timescale 1ns/1ps
`include "hostport_consts.svh"
`default_nettype none
// Contract
// - select 000 moves sixteen-bit packet data
// - select 001 moves eight-bit internal register
// - select 010 loads pointer low byte
// - select 011 loads pointer high byte
// - top select bit set means idle
// - port select low throughout every access
// - read starts on read strobe fall
// - write starts on write strobe fall
// - interrupt on four completion events
// - causes readable in status at 2000
// - write 1806 clears management cause
// - write 1c04 clears eeprom cause
// - write 6403 clears receive cause
// - write 6411 clears transmit cause
module switch_host_port (
    input wire logic pclk,
    input wire logic presetn,
    host_port_if.device link,
    input wire logic ev_phy_mgmt_done,
    input wire logic ev_eeprom_done,
    input wire logic ev_rx_packet,
    input wire logic ev_tx_done,
    output logic [15:0] pkt_rx_data,
    output logic pkt_rx_valid,
    input wire logic [15:0] pkt_tx_data,
    output logic pkt_tx_taken,
    output logic [15:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    input wire logic [7:0] reg_rdata
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] sel_s1_r, sel_s2_r;
    logic [15:0] data_s1_r, data_s2_r;
    logic cs_s1_r, cs_s2_r;
    logic rd_s1_r, rd_s2_r, rd_d_r;
    logic wr_s1_r, wr_s2_r, wr_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_s1_r <= `SEL_IDLE;
            sel_s2_r <= `SEL_IDLE;
            data_s1_r <= 16'h0000;
            data_s2_r <= 16'h0000;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            rd_s1_r <= 1'b1;
            rd_s2_r <= 1'b1;
            rd_d_r <= 1'b1;
            wr_s1_r <= 1'b1;
            wr_s2_r <= 1'b1;
            wr_d_r <= 1'b1;
        end else begin
            sel_s1_r <= link.cmd_select;
            sel_s2_r <= sel_s1_r;
            data_s1_r <= link.host_data_bus;
            data_s2_r <= data_s1_r;
            cs_s1_r <= link.port_select_n;
            cs_s2_r <= cs_s1_r;
            rd_s1_r <= link.read_strobe_n;
            rd_s2_r <= rd_s1_r;
            rd_d_r <= rd_s2_r;
            wr_s1_r <= link.write_strobe_n;
            wr_s2_r <= wr_s1_r;
            wr_d_r <= wr_s2_r;
        end
    end

    // ****************************************
    // access decode
    // ****************************************
    logic active, rd_start, wr_start;
    // access counts only while selected and not idle
    // idle and select
    assign active = !cs_s2_r && !sel_s2_r[2];
    assign rd_start = rd_d_r && !rd_s2_r && active;
    assign wr_start = wr_d_r && !wr_s2_r && active;

    logic [15:0] ptr_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= 16'h0000;
        end else if (wr_start && sel_s2_r == `SEL_PTR_LOW) begin
            ptr_r[7:0] <= data_s2_r[7:0];
        end else if (wr_start && sel_s2_r == `SEL_PTR_HIGH) begin
            ptr_r[15:8] <= data_s2_r[7:0];
        end
    end

    logic reg_wr, reg_rd, pkt_wr, pkt_rd;
    assign reg_wr = wr_start && sel_s2_r == `SEL_REGISTER;
    assign reg_rd = rd_start && sel_s2_r == `SEL_REGISTER;
    assign pkt_wr = wr_start && sel_s2_r == `SEL_PACKET;
    assign pkt_rd = rd_start && sel_s2_r == `SEL_PACKET;

    // ****************************************
    // interrupt causes
    // ****************************************
    logic [3:0] cause_r, ev_in, clr;
    assign ev_in = {ev_tx_done, ev_rx_packet, ev_eeprom_done, ev_phy_mgmt_done};
    assign clr[`CAUSE_PHY_MGMT] = reg_wr && ptr_r == `ADDR_PHY_MGMT_IRQ_CLEAR;
    assign clr[`CAUSE_EEPROM] = reg_wr && ptr_r == `ADDR_EEPROM_IRQ_CLEAR;
    assign clr[`CAUSE_RX_PACKET] = reg_wr && ptr_r == `ADDR_RX_PACKET_IRQ_CLEAR;
    assign clr[`CAUSE_TX_DONE] = reg_wr && ptr_r == `ADDR_TX_DONE_IRQ_CLEAR;

    // set beats clear so a coincident event is kept
    // sticky causes
    genvar i;
    generate
        for (i = 0; i < `CAUSE_COUNT; i++) begin : g_cause
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cause_r[i] <= 1'b0;
                end else if (ev_in[i]) begin
                    cause_r[i] <= 1'b1;
                end else if (clr[i]) begin
                    cause_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.irq_out <= 1'b0;
        end else begin
            link.irq_out <= |cause_r;
        end
    end

    // ****************************************
    // read data drive
    // ****************************************
    // data held until the read strobe rises again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.dev_data_out <= 16'h0000;
            link.dev_data_oe <= 1'b0;
        end else if (reg_rd) begin
            link.dev_data_oe <= 1'b1;
            if (ptr_r == `ADDR_IRQ_CAUSE_STATUS) begin
                link.dev_data_out <= {12'h000, cause_r};
            end else begin
                link.dev_data_out <= {8'h00, reg_rdata};
            end
        end else if (pkt_rd) begin
            link.dev_data_oe <= 1'b1;
            link.dev_data_out <= pkt_tx_data;
        end else if (rd_s2_r || cs_s2_r) begin
            link.dev_data_oe <= 1'b0;
        end
    end

    // ****************************************
    // user side
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_rx_data <= 16'h0000;
            pkt_rx_valid <= 1'b0;
            pkt_tx_taken <= 1'b0;
            reg_addr <= 16'h0000;
            reg_wdata <= 8'h00;
            reg_write <= 1'b0;
        end else begin
            pkt_rx_valid <= pkt_wr;
            pkt_tx_taken <= pkt_rd;
            reg_write <= reg_wr;
            reg_addr <= ptr_r;
            if (pkt_wr) begin
                pkt_rx_data <= data_s2_r;
            end
            if (reg_wr) begin
                reg_wdata <= data_s2_r[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// File: src/host_port_master.sv
// host end: apb-driven controller performing strobed port accesses
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "hostport_consts.svh"
`default_nettype none
module host_port_master (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    host_port_if.host link
);
    // ****************************************
    // registers
    // ****************************************
    logic [2:0] sel_r;
    logic dir_r;
    logic [15:0] wdata_r, rdata_r;
    logic [1:0] mask_r, evst_r, ev;
    logic irq_s1_r, irq_s2_r, irq_d_r;
    logic [7:0] cnt_r;
    hostport_pkg::host_state_t st_r;
    logic wr_acc, go, done;

    assign wr_acc = psel && penable && pwrite;
    assign go = wr_acc && paddr == `APB_CTRL && pwdata[`CTRL_GO]
                && st_r == hostport_pkg::ST_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= `SEL_IDLE;
            dir_r <= 1'b0;
            wdata_r <= 16'h0000;
            mask_r <= 2'h0;
        end else if (wr_acc) begin
            if (go) begin
                sel_r <= pwdata[`CTRL_SEL_LSB +: 3];
                dir_r <= pwdata[`CTRL_WRITE];
            end
            if (paddr == `APB_WDATA) begin
                wdata_r <= pwdata[15:0];
            end
            if (paddr == `APB_IRQ_MASK) begin
                mask_r <= pwdata[1:0];
            end
        end
    end

    // ****************************************
    // strobe sequencer
    // ****************************************
    // select held whole access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= hostport_pkg::ST_IDLE;
            cnt_r <= 8'h00;
            rdata_r <= 16'h0000;
            link.cmd_select <= `SEL_IDLE;
            link.port_select_n <= 1'b1;
            link.read_strobe_n <= 1'b1;
            link.write_strobe_n <= 1'b1;
            link.host_data_out <= 16'h0000;
            link.host_data_oe <= 1'b0;
        end else begin
            case (st_r)
                hostport_pkg::ST_IDLE: begin
                    if (go) begin
                        st_r <= hostport_pkg::ST_SETUP;
                        cnt_r <= `SETUP_CYCLES;
                        link.cmd_select <= pwdata[`CTRL_SEL_LSB +: 3];
                        link.port_select_n <= 1'b0;
                        link.host_data_out <= wdata_r;
                        link.host_data_oe <= pwdata[`CTRL_WRITE];
                    end
                end
                hostport_pkg::ST_SETUP: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        st_r <= hostport_pkg::ST_STROBE;
                        cnt_r <= `STROBE_CYCLES;
                        link.read_strobe_n <= dir_r;
                        link.write_strobe_n <= !dir_r;
                    end
                end
                hostport_pkg::ST_STROBE: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        st_r <= hostport_pkg::ST_HOLD;
                        cnt_r <= `SETUP_CYCLES;
                        rdata_r <= link.host_data_bus;
                        link.read_strobe_n <= 1'b1;
                        link.write_strobe_n <= 1'b1;
                    end
                end
                hostport_pkg::ST_HOLD: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        st_r <= hostport_pkg::ST_IDLE;
                        link.cmd_select <= `SEL_IDLE;
                        link.port_select_n <= 1'b1;
                        link.host_data_oe <= 1'b0;
                    end
                end
                default: begin
                    st_r <= hostport_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // events and interrupt
    // ****************************************
    // pin irq passes two flops before edge logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            irq_d_r <= 1'b0;
        end else begin
            irq_s1_r <= link.irq_out;
            irq_s2_r <= irq_s1_r;
            irq_d_r <= irq_s2_r;
        end
    end

    assign done = st_r == hostport_pkg::ST_HOLD && cnt_r == 8'h01;
    assign ev = {irq_s2_r && !irq_d_r, done};

    // set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evst_r <= 2'h0;
        end else if (wr_acc && paddr == `APB_IRQ_STATUS) begin
            evst_r <= (evst_r & ~pwdata[1:0]) | ev;
        end else begin
            evst_r <= evst_r | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evst_r & mask_r);
        end
    end

    // ****************************************
    // apb read side, zero wait states
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    `APB_CTRL: prdata <= {25'h0, sel_r, 2'h0, dir_r, 1'b0};
                    `APB_WDATA: prdata <= {16'h0000, wdata_r};
                    `APB_RDATA: prdata <= {16'h0000, rdata_r};
                    `APB_STATUS: prdata <= {30'h0, irq_s2_r,
                                            st_r != hostport_pkg::ST_IDLE};
                    `APB_IRQ_MASK: prdata <= {30'h0, mask_r};
                    `APB_IRQ_STATUS: prdata <= {30'h0, evst_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/host_port_monitor.sv
// checker of the port wires between controller and device
`timescale 1ns/1ps
`include "hostport_consts.svh"
`default_nettype none
module host_port_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] cmd_select,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic port_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic irq_out
);
    logic [7:0] since_wr_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****
    // clear window
    // ****
    // cause clears only follow a register write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_wr_r <= 8'hff;
        end else if (!write_strobe_n && cmd_select == `SEL_REGISTER) begin
            since_wr_r <= 8'h00;
        end else if (since_wr_r != 8'hff) begin
            since_wr_r <= since_wr_r + 8'h01;
        end
    end
    a_idle_when_free: assert property (port_select_n == cmd_select[2])
        else $error("select code and port select disagree");
    a_read_in_access: assert property (!read_strobe_n |-> !port_select_n && write_strobe_n)
        else $error("read strobe outside an access");
    a_write_in_access: assert property (!write_strobe_n |-> !port_select_n && read_strobe_n)
        else $error("write strobe outside an access");
    a_sel_steady: assert property (!port_select_n && $past(!port_select_n) |-> $stable(cmd_select))
        else $error("select code moved during access");
    a_read_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*4] ##1 read_strobe_n)
        else $error("read strobe width wrong");
    a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
        else $error("write strobe width wrong");
    a_read_drive: assert property ($fell(read_strobe_n) |-> ##[1:5] dev_data_oe)
        else $error("device did not drive read data");
    a_host_drives_write: assert property (!write_strobe_n |-> host_data_oe && !dev_data_oe)
        else $error("data bus not owned by host on write");
    a_irq_clear_cause: assert property ($fell(irq_out) |-> since_wr_r < 8'h0c)
        else $error("interrupt fell without a clear write");
    c_read: cover property ($fell(read_strobe_n));
    c_packet_write: cover property ($fell(write_strobe_n) && cmd_select == `SEL_PACKET);
    c_irq_clear: cover property ($fell(irq_out));
endmodule
`default_nettype wire

// File: testbench/switch_host_ide_port_tb.sv
// bench: controller and device joined through the port link
`timescale 1ns/1ps
`include "hostport_consts.svh"
`default_nettype none
module switch_host_ide_port_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] ev = 4'h0;
    logic [15:0] pkt_rx_data;
    logic [15:0] pkt_tx_data = 16'h0000;
    logic pkt_rx_valid;
    logic pkt_tx_taken;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic [7:0] reg_rdata = 8'h00;
    logic [31:0] rd;
    logic [3:0] pend;
    logic [15:0] clr_addr [4] = '{`ADDR_PHY_MGMT_IRQ_CLEAR, `ADDR_EEPROM_IRQ_CLEAR,
        `ADDR_RX_PACKET_IRQ_CLEAR, `ADDR_TX_DONE_IRQ_CLEAR};
    int errors = 0;
    int check_count = 0;
    int rx_n = 0;
    int tx_n = 0;
    int wr_n = 0;

    always #2 pclk = ~pclk;
    // pulse counters on the device user side
    always @(posedge pclk) begin
        if (pkt_rx_valid === 1'b1) rx_n <= rx_n + 1;
        if (pkt_tx_taken === 1'b1) tx_n <= tx_n + 1;
        if (reg_write === 1'b1) wr_n <= wr_n + 1;
    end

    host_port_if i_host_port_if ();
    host_port_master i_host_port_master (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .link(i_host_port_if.host));
    switch_host_port i_switch_host_port (.pclk(pclk), .presetn(presetn),
        .link(i_host_port_if.device), .ev_phy_mgmt_done(ev[0]), .ev_eeprom_done(ev[1]),
        .ev_rx_packet(ev[2]), .ev_tx_done(ev[3]), .pkt_rx_data(pkt_rx_data),
        .pkt_rx_valid(pkt_rx_valid), .pkt_tx_data(pkt_tx_data), .pkt_tx_taken(pkt_tx_taken),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_rdata(reg_rdata));
    host_port_monitor i_host_port_monitor (.pclk(pclk), .presetn(presetn),
        .cmd_select(i_host_port_if.cmd_select), .host_data_oe(i_host_port_if.host_data_oe),
        .dev_data_oe(i_host_port_if.dev_data_oe),
        .port_select_n(i_host_port_if.port_select_n),
        .read_strobe_n(i_host_port_if.read_strobe_n),
        .write_strobe_n(i_host_port_if.write_strobe_n), .irq_out(i_host_port_if.irq_out));

    // ****
    // tasks
    // ****
    task automatic results();
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        errors++;
        $display("BAD %0t wait ran out", $time);
        results();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) tmo();
        rd = prdata;
        chk({31'h0, pslverr}, 32'h0000_0000);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic port(input logic [2:0] sel, input logic wr, input logic [15:0] d);
        int n;
        apb(1'b1, `APB_WDATA, {16'h0000, d});
        apb(1'b1, `APB_CTRL, {25'h0, sel, 2'b00, wr, 1'b1});
        n = 0;
        do begin
            apb(1'b0, `APB_STATUS, 32'h0000_0000);
            n++;
        end while (rd[`STATUS_BUSY] !== 1'b0 && n < 50);
        if (rd[`STATUS_BUSY] !== 1'b0) tmo();
        if (!wr) apb(1'b0, `APB_RDATA, 32'h0000_0000);
    endtask

    // junk in the upper byte must not reach the pointer
    task automatic reg_acc(input logic [15:0] a, input logic wr, input logic [7:0] d);
        port(`SEL_PTR_LOW, 1'b1, {8'hc3, a[7:0]});
        port(`SEL_PTR_HIGH, 1'b1, {8'h3c, a[15:8]});
        port(`SEL_REGISTER, wr, {8'h99, d});
    endtask

    // ****
    // sequence
    // ****
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        reg_acc(16'h1234, 1'b1, 8'ha5);
        chk(reg_addr, 16'h1234);
        chk(reg_wdata, 8'ha5);
        chk(wr_n, 1);
        chk(i_host_port_if.cmd_select, `SEL_IDLE);
        chk(i_host_port_if.port_select_n, 1);
        reg_rdata <= 8'h5e;
        reg_acc(16'h0042, 1'b0, 8'h00);
        chk(rd[7:0], 8'h5e);
        chk(wr_n, 1);
        port(`SEL_PACKET, 1'b1, 16'hbeef);
        chk(pkt_rx_data, 16'hbeef);
        chk(rx_n, 1);
        pkt_tx_data <= 16'h5a3c;
        port(`SEL_PACKET, 1'b0, 16'h0000);
        chk(rd[15:0], 16'h5a3c);
        chk(tx_n, 1);
        pend = 4'h0;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            ev <= 4'h1 << i;
            @(posedge pclk);
            ev <= 4'h0;
            pend[i] = 1'b1;
            repeat (3) @(posedge pclk);
            chk(i_host_port_if.irq_out, 1);
            apb(1'b0, `APB_STATUS, 32'h0000_0000);
            chk(rd[`STATUS_IRQ_PIN], 1);
            reg_acc(`ADDR_IRQ_CAUSE_STATUS, 1'b0, 8'h00);
            chk(rd[3:0], pend);
        end
        // controller events: access done and device interrupt rise
        apb(1'b0, `APB_IRQ_STATUS, 32'h0000_0000);
        chk(rd[1:0], 2'b11);
        chk(irq, 0);
        apb(1'b1, `APB_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(irq, 1);
        for (int i = 0; i < 4; i++) begin
            reg_acc(clr_addr[i], 1'b1, 8'h00);
            pend[i] = 1'b0;
            repeat (3) @(posedge pclk);
            chk(i_host_port_if.irq_out, |pend);
            reg_acc(`ADDR_IRQ_CAUSE_STATUS, 1'b0, 8'h00);
            chk(rd[3:0], pend);
        end
        apb(1'b0, `APB_STATUS, 32'h0000_0000);
        chk(rd[1:0], 2'b00);
        apb(1'b0, `APB_CTRL, 32'h0000_0000);
        chk(rd, {25'h0, `SEL_REGISTER, 4'h0});
        apb(1'b1, `APB_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        results();
    end
endmodule
`default_nettype wire
